// File: sms_far_model.sv
// far-side model: serial bit ticks and a two-direction dma channel
`timescale 1ns/1ps
module sms_far_model
	import sms_pkg::*;
#(
	parameter int TX_DLY = 4,
	parameter int RX_DLY = 20
)
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// bench commands
	input wire logic dma_go,
	input wire logic xfer_active,
	// engine and dma side
	output logic bit_tick,
	output logic dma_tx_on,
	output logic dma_rx_on,
	output logic dma_tx_done,
	output logic dma_rx_done
);
	int cnt;
	// both directions stay on past the slower done, so the flag has to wait for it
	always_ff @(posedge ref_clk)
	begin
		if (reset || dma_go)
		begin
			cnt <= 0;
			dma_tx_on <= dma_go;
			dma_rx_on <= dma_go;
		end
		else if (dma_rx_on)
		begin
			cnt <= cnt + 1;
			dma_tx_on <= (cnt != RX_DLY + 1);
			dma_rx_on <= (cnt != RX_DLY + 1);
		end
		bit_tick <= !reset && xfer_active && !bit_tick;
		dma_tx_done <= !reset && dma_rx_on && (cnt == TX_DLY);
		dma_rx_done <= !reset && dma_rx_on && (cnt == RX_DLY);
	end
endmodule

// File: sms_pkg.sv
// package for the spi master status flags block
package sms_pkg;
	localparam logic [7:0] SMS_ADDR_STATUS = 8'h10;
	localparam logic [7:0] SMS_ADDR_IEN = 8'h18;
	localparam logic [7:0] SMS_ADDR_CTRL = 8'h40;
	localparam int SMS_ADDR_W = 8;
	localparam int SMS_BIT_DONE = 0;
	localparam int SMS_BIT_DMA = 1;
	localparam int SMS_BIT_TXOVF = 2;
	localparam int SMS_BIT_RXUDF = 3;
	localparam int SMS_BIT_PROG = 4;
	localparam int SMS_BIT_TXFULL = 8;
	localparam int SMS_BIT_STOP = 0;
	localparam int SMS_BIT_CLOSE = 1;
	localparam logic [4:0] SMS_FLAGS_RST = 5'h00;
	localparam logic [4:0] SMS_IEN_RST = 5'h00;
	localparam logic [31:0] SMS_RD_NONE = 32'h00000000;
	localparam logic [2:0] SMS_BITS_PER_BYTE = 3'h7;
	typedef enum logic [1:0]
	{
		SMS_MANUAL = 2'b00,
		SMS_DMA = 2'b01,
		SMS_DESC = 2'b11
	} sms_mode_e;
	typedef enum logic [1:0]
	{
		SMS_IDLE = 2'b00,
		SMS_RUN = 2'b01,
		SMS_DRAIN = 2'b11,
		SMS_FIN = 2'b10
	} sms_state_e;
endpackage

// File: sms_status.sv
// status flags of the spi master: error and completion events
`timescale 1ns/1ps
module sms_status
	import sms_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// register port
	input wire logic [SMS_ADDR_W-1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [31:0] rdata,
	// engine and buffer events
	input wire logic [1:0] op_mode,
	input wire logic tx_full,
	input wire logic prog_err,
	input wire logic rx_pop_empty,
	input wire logic tx_push_full,
	input wire logic bit_tick,
	input wire logic xfer_active,
	input wire logic len_match,
	// dma handshake
	input wire logic dma_tx_on,
	input wire logic dma_rx_on,
	input wire logic dma_tx_done,
	input wire logic dma_rx_done,
	input wire logic desc_done,
	input wire logic desc_last,
	// outputs
	output logic halt_req,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	logic [4:0] flags_r, flags_nxt;
	logic [4:0] ien_r, ien_nxt;
	logic [1:0] ctrl_r, ctrl_nxt;
	logic txfull_r, txfull_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic tx_seen_r, tx_seen_nxt;
	logic rx_seen_r, rx_seen_nxt;
	logic [2:0] bcnt_r, bcnt_nxt;
	sms_state_e st_r, st_nxt;
	logic [4:0] set_v;
	logic dma_fire, job_fire, halt_fire;
	sms_mode_e mode;

	function automatic logic hit(input logic [SMS_ADDR_W-1:0] a,
		input logic [SMS_ADDR_W-1:0] b);
		hit = (a == b);
	endfunction

	assign mode = sms_mode_e'(op_mode);

	////////////////////////////////////////////////////////////////////////
	// dma completion: wait for every running direction before firing
	always_comb
	begin
		tx_seen_nxt = tx_seen_r;
		rx_seen_nxt = rx_seen_r;
		dma_fire = 1'b0;
		if (mode != SMS_MANUAL)
		begin
			if (dma_tx_done)
				tx_seen_nxt = 1'b1;
			if (dma_rx_done)
				rx_seen_nxt = 1'b1;
			if ((tx_seen_nxt || !dma_tx_on) && (rx_seen_nxt || !dma_rx_on)
				&& (tx_seen_nxt || rx_seen_nxt))
			begin
				dma_fire = 1'b1;
				tx_seen_nxt = 1'b0;
				rx_seen_nxt = 1'b0;
			end
		end
		else
		begin
			tx_seen_nxt = 1'b0;
			rx_seen_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// halt sequencing: let the byte in flight finish before reporting
	always_comb
	begin
		st_nxt = st_r;
		bcnt_nxt = bcnt_r;
		halt_fire = 1'b0;
		unique case (st_r)
			SMS_IDLE:
			begin
				if (ctrl_r[SMS_BIT_STOP])
					st_nxt = xfer_active ? SMS_RUN : SMS_FIN;
			end
			SMS_RUN:
			begin
				if (bit_tick)
				begin
					bcnt_nxt = bcnt_r + 3'h1;
					if (bcnt_r == SMS_BITS_PER_BYTE)
						st_nxt = SMS_DRAIN;
				end
			end
			SMS_DRAIN:
				st_nxt = SMS_FIN;
			SMS_FIN:
			begin
				halt_fire = 1'b1;
				bcnt_nxt = 3'h0;
				st_nxt = SMS_IDLE;
			end
		endcase
		if (bit_tick && st_r == SMS_IDLE)
			bcnt_nxt = bcnt_r + 3'h1;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		set_v = 5'h00;
		job_fire = 1'b0;
		unique case (mode)
			SMS_MANUAL: job_fire = len_match;
			SMS_DMA: job_fire = dma_fire;
			SMS_DESC: job_fire = desc_done && desc_last;
			default: job_fire = 1'b0;
		endcase
		if (ctrl_r[SMS_BIT_CLOSE] && dma_fire)
			job_fire = 1'b1;
		set_v[SMS_BIT_DMA] = dma_fire || (mode == SMS_DESC && desc_done && dma_tx_on);
		set_v[SMS_BIT_DONE] = job_fire || halt_fire;
		set_v[SMS_BIT_PROG] = prog_err;
		set_v[SMS_BIT_RXUDF] = rx_pop_empty;
		set_v[SMS_BIT_TXOVF] = tx_push_full;
	end

	////////////////////////////////////////////////////////////////////////
	// register file and read path
	always_comb
	begin
		flags_nxt = flags_r;
		ien_nxt = ien_r;
		ctrl_nxt = ctrl_r;
		rdata_nxt = SMS_RD_NONE;
		if (wr_stb && hit(addr, SMS_ADDR_STATUS))
			flags_nxt = flags_r & ~wdata[4:0];
		if (wr_stb && hit(addr, SMS_ADDR_IEN))
			ien_nxt = wdata[4:0];
		if (wr_stb && hit(addr, SMS_ADDR_CTRL))
			ctrl_nxt = wdata[1:0];
		if (halt_fire)
			ctrl_nxt[SMS_BIT_STOP] = 1'b0;
		flags_nxt = flags_nxt | set_v;
		if (rd_stb)
		begin
			if (hit(addr, SMS_ADDR_STATUS))
				rdata_nxt = {23'h000000, txfull_r, 3'h0, flags_r};
			else if (hit(addr, SMS_ADDR_IEN))
				rdata_nxt = {27'h0000000, ien_r};
			else if (hit(addr, SMS_ADDR_CTRL))
				rdata_nxt = {30'h00000000, ctrl_r};
		end
		txfull_nxt = tx_full;
		irq_nxt = |(flags_nxt & ien_nxt);
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			flags_r <= SMS_FLAGS_RST;
			ien_r <= SMS_IEN_RST;
			ctrl_r <= 2'h0;
			txfull_r <= 1'b0;
			rdata_r <= SMS_RD_NONE;
			irq_r <= 1'b0;
			tx_seen_r <= 1'b0;
			rx_seen_r <= 1'b0;
			bcnt_r <= 3'h0;
			st_r <= SMS_IDLE;
		end
		else
		begin
			flags_r <= flags_nxt;
			ien_r <= ien_nxt;
			ctrl_r <= ctrl_nxt;
			txfull_r <= txfull_nxt;
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			tx_seen_r <= tx_seen_nxt;
			rx_seen_r <= rx_seen_nxt;
			bcnt_r <= bcnt_nxt;
			st_r <= st_nxt;
		end
	end

	assign rdata = rdata_r;
	assign irq = irq_r;
	assign halt_req = ctrl_r[SMS_BIT_STOP];

	////////////////////////////////////////////////////////////////////////
	a_txfull_mirror: assert property (@(posedge ref_clk) disable iff (reset)
		##1 txfull_r == $past(tx_full))
		else $error("tx full bit does not follow buffer");
	a_prog_sticky: assert property (@(posedge ref_clk) disable iff (reset)
		prog_err |=> flags_r[SMS_BIT_PROG])
		else $error("programming error not flagged");
	a_rx_underflow: assert property (@(posedge ref_clk) disable iff (reset)
		rx_pop_empty |=> flags_r[SMS_BIT_RXUDF])
		else $error("underflow not flagged");
	a_tx_overflow: assert property (@(posedge ref_clk) disable iff (reset)
		tx_push_full |=> flags_r[SMS_BIT_TXOVF])
		else $error("overflow not flagged");
	a_dma_done_set: assert property (@(posedge ref_clk) disable iff (reset)
		dma_fire |=> flags_r[SMS_BIT_DMA])
		else $error("dma done not flagged");
	a_dma_pair: assert property (@(posedge ref_clk) disable iff (reset)
		(mode == SMS_DMA && dma_tx_on && dma_rx_on && dma_tx_done && !dma_rx_done
		&& !rx_seen_r) |-> !dma_fire)
		else $error("dma flag before both directions");
	a_close_pair: assert property (@(posedge ref_clk) disable iff (reset)
		(ctrl_r[SMS_BIT_CLOSE] && dma_fire) |=> flags_r[SMS_BIT_DONE] && flags_r[SMS_BIT_DMA])
		else $error("auto close flags not together");
	a_manual_done: assert property (@(posedge ref_clk) disable iff (reset)
		(mode == SMS_MANUAL && len_match) |=> flags_r[SMS_BIT_DONE])
		else $error("manual job not flagged");
	a_desc_last: assert property (@(posedge ref_clk) disable iff (reset)
		(mode == SMS_DESC && desc_done && !desc_last && !dma_fire && !halt_fire
		&& !ctrl_r[SMS_BIT_CLOSE]) |-> !set_v[SMS_BIT_DONE])
		else $error("job flag on non-last buffer");
	a_halt_done: assert property (@(posedge ref_clk) disable iff (reset)
		(st_r == SMS_DRAIN) |=> ##1 flags_r[SMS_BIT_DONE])
		else $error("halt did not complete job");
	a_irq_gate: assert property (@(posedge ref_clk) disable iff (reset)
		irq |-> |(flags_r & ien_r))
		else $error("interrupt without enabled flag");
	a_set_wins: assert property (@(posedge ref_clk) disable iff (reset)
		(wr_stb && hit(addr, SMS_ADDR_STATUS))
		|=> ((flags_r & $past(set_v)) == $past(set_v)))
		else $error("clear beat a set");
	a_clear_one: assert property (@(posedge ref_clk) disable iff (reset)
		(wr_stb && hit(addr, SMS_ADDR_STATUS) && wdata[SMS_BIT_PROG] && !prog_err)
		|=> !flags_r[SMS_BIT_PROG])
		else $error("write one did not clear");
	a_prog_hold: assert property (@(posedge ref_clk) disable iff (reset)
		(flags_r[SMS_BIT_PROG] && !(wr_stb && hit(addr, SMS_ADDR_STATUS) && wdata[SMS_BIT_PROG]))
		|=> flags_r[SMS_BIT_PROG])
		else $error("error flag dropped without clear");
	a_manual_quiet: assert property (@(posedge ref_clk) disable iff (reset)
		(mode == SMS_MANUAL && !flags_r[SMS_BIT_DMA]) |=> !flags_r[SMS_BIT_DMA])
		else $error("dma flag raised in manual mode");
	a_desc_buffer: assert property (@(posedge ref_clk) disable iff (reset)
		(mode == SMS_DESC && desc_done && dma_tx_on) |=> flags_r[SMS_BIT_DMA])
		else $error("buffer completion not flagged");
	a_dma_job: assert property (@(posedge ref_clk) disable iff (reset)
		(mode == SMS_DMA && dma_fire) |=> (flags_r[SMS_BIT_DONE] && flags_r[SMS_BIT_DMA]))
		else $error("dma job flag not with dma flag");
	a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (reset)
		(rd_stb && hit(addr, SMS_ADDR_STATUS))
		|=> (rdata[7:5] == 3'h0 && rdata[31:9] == 23'h000000))
		else $error("reserved status bits not zero");
	// halt steps: last bit of the byte in flight, then the job flag three edges on
	sequence s_last_bit;
		st_r == SMS_RUN && bit_tick && bcnt_r == SMS_BITS_PER_BYTE;
	endsequence
	sequence s_job_flagged;
		##3 flags_r[SMS_BIT_DONE];
	endsequence
	a_halt_byte: assert property (@(posedge ref_clk) disable iff (reset)
		s_last_bit |-> s_job_flagged)
		else $error("halt did not close the byte");
endmodule

// File: tb_sms_status.sv
// self-checking bench for the spi master status flags
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_sms_status
	import sms_pkg::*;
;
	typedef struct packed
	{
		logic [1:0] m;
		logic [5:0] e;
		logic [31:0] x;
	} sms_row_s;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic tx_full = 1'b0;
	logic xfer_active = 1'b0;
	logic dma_go = 1'b0;
	logic [1:0] op_mode = 2'h0;
	logic [5:0] ev = 6'h00;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic halt_req, irq, bit_tick, dma_tx_on, dma_rx_on, dma_tx_done, dma_rx_done;
	int err_total = 0;
	int checks_done = 0;
	int n;
	// ev: tx push full, rx pop empty, prog error, length match, buffer done, last
	sms_row_s rows [6] = '{'{2'h0, 6'h01, 32'h4}, '{2'h0, 6'h02, 32'h8},
		'{2'h0, 6'h04, 32'h10}, '{2'h0, 6'h08, 32'h1}, '{2'h3, 6'h10, 32'h0},
		'{2'h3, 6'h30, 32'h1}};
	////////////////////////////////////////////////////////////////////////////
	sms_status u_sms_status (.ref_clk(ref_clk), .reset(reset), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.op_mode(op_mode), .tx_full(tx_full), .prog_err(ev[2]),
		.rx_pop_empty(ev[1]), .tx_push_full(ev[0]), .bit_tick(bit_tick),
		.xfer_active(xfer_active), .len_match(ev[3]), .dma_tx_on(dma_tx_on),
		.dma_rx_on(dma_rx_on), .dma_tx_done(dma_tx_done), .dma_rx_done(dma_rx_done),
		.desc_done(ev[4]), .desc_last(ev[5]), .halt_req(halt_req), .irq(irq));
	sms_far_model u_sms_far_model (.ref_clk(ref_clk), .reset(reset), .dma_go(dma_go),
		.xfer_active(xfer_active), .bit_tick(bit_tick), .dma_tx_on(dma_tx_on),
		.dma_rx_on(dma_rx_on), .dma_tx_done(dma_tx_done), .dma_rx_done(dma_rx_done));
	////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] k = 32'hffffffff);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		`CHK(rdata & k, x)
		@(posedge ref_clk);
	endtask
	task automatic chk_irq(input logic x);
		#1;
		`CHK(irq, x)
		@(posedge ref_clk);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		chk_rd(SMS_ADDR_STATUS, 32'h0);
		chk_rd(SMS_ADDR_IEN, 32'h0);
		$display("test reset done");
		foreach (rows[i])
		begin
			op_mode <= rows[i].m;
			ev <= rows[i].e;
			@(posedge ref_clk);
			ev <= 6'h00;
			@(posedge ref_clk);
			// dma flag meaning is open in buffer mode without dma running
			chk_rd(SMS_ADDR_STATUS, rows[i].x, rows[i].m == 2'h3 ? 32'hfffffffd : '1);
			wr(SMS_ADDR_STATUS, 32'h1f);
			chk_rd(SMS_ADDR_STATUS, 32'h0, rows[i].m == 2'h3 ? 32'hfffffffd : '1);
		end
		$display("test table done");
		op_mode <= SMS_MANUAL;
		ev <= 6'h04;
		addr <= SMS_ADDR_STATUS;
		wdata <= 32'h10;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		ev <= 6'h00;
		wr_stb <= 1'b0;
		@(posedge ref_clk);
		wr(SMS_ADDR_STATUS, 32'h0);
		chk_rd(SMS_ADDR_STATUS, 32'h10);
		wr(SMS_ADDR_IEN, 32'h10);
		chk_irq(1'b1);
		wr(SMS_ADDR_IEN, 32'h0f);
		chk_irq(1'b0);
		wr(SMS_ADDR_IEN, 32'h10);
		wr(SMS_ADDR_STATUS, 32'h10);
		chk_irq(1'b0);
		tx_full <= 1'b1;
		wr(SMS_ADDR_STATUS, 32'hffffffff);
		chk_rd(SMS_ADDR_STATUS, 32'h100);
		tx_full <= 1'b0;
		chk_rd(8'h3c, 32'h0);
		$display("test clear irq done");
		wr(SMS_ADDR_CTRL, 32'h2);
		op_mode <= SMS_DMA;
		dma_go <= 1'b1;
		@(posedge ref_clk);
		dma_go <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk_rd(SMS_ADDR_STATUS, 32'h0);
		repeat (20) @(posedge ref_clk);
		chk_rd(SMS_ADDR_STATUS, 32'h3);
		wr(SMS_ADDR_STATUS, 32'h3);
		$display("test dma done");
		// buffer mode: one buffer ends mid-run, then the channel closes with auto-close on
		wr(SMS_ADDR_CTRL, 32'h0);
		op_mode <= SMS_DESC;
		dma_go <= 1'b1;
		@(posedge ref_clk);
		dma_go <= 1'b0;
		ev <= 6'h10;
		@(posedge ref_clk);
		ev <= 6'h00;
		chk_rd(SMS_ADDR_STATUS, 32'h2);
		wr(SMS_ADDR_STATUS, 32'h2);
		wr(SMS_ADDR_CTRL, 32'h2);
		repeat (20) @(posedge ref_clk);
		chk_rd(SMS_ADDR_STATUS, 32'h3);
		chk_irq(1'b0);
		wr(SMS_ADDR_IEN, 32'h2);
		chk_irq(1'b1);
		wr(SMS_ADDR_STATUS, 32'h3);
		chk_irq(1'b0);
		$display("test buffer dma done");
		op_mode <= SMS_MANUAL;
		xfer_active <= 1'b1;
		wr(SMS_ADDR_CTRL, 32'h1);
		`CHK(halt_req, 1'b1)
		for (n = 0; n < 200 && halt_req !== 1'b0; n++)
			@(posedge ref_clk);
		if (n == 200)
		begin
			err_total++;
			end_sim();
		end
		xfer_active <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk_rd(SMS_ADDR_STATUS, 32'h1);
		$display("test halt done");
		wr(SMS_ADDR_IEN, 32'h1f);
		chk_irq(1'b1);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		chk_irq(1'b0);
		chk_rd(SMS_ADDR_STATUS, 32'h0);
		chk_rd(SMS_ADDR_IEN, 32'h0);
		`CHK(halt_req, 1'b0)
		$display("test reset again done");
		end_sim();
	end
endmodule
